// [hdl/ssst_pkg.sv]
// Summary of operation
// - Each word is 7 or 8 bits long, chosen by a configuration bit.
// - The data output is released to high impedance while unselected.
// - While select is high and the select enable bit is 1, serial clock edges neither shift nor sample.
// - Data phase 0: shift out on falling edges, sample on rising edges.
// - Data phase 1: a loaded word shows its first bit at once, even unselected.
// - Data phase 1 and selected: shift out on rising, sample on falling edges.
// - Data phase picks output at the first clock edge or half a period early.
// - Clock phase 0 keeps the serial clock as is, 1 inverts it.
// - The interrupt marks transfer end (single) or buffer empty (continuous).
// - Overrun is the only error that the channel flags.
// - The select enable bit passes the select pin when 1, ignores it when 0.
// - Transmit data written while the buffer is full overwrites it.
package ssst_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [11:0] OFS_CONFIG   = 12'h000;
	localparam logic [11:0] OFS_START    = 12'h004;
	localparam logic [11:0] OFS_STOP     = 12'h008;
	localparam logic [11:0] OFS_STATUS   = 12'h00C;
	localparam logic [11:0] OFS_TXDATA   = 12'h010;
	localparam logic [11:0] OFS_RXDATA   = 12'h014;
	localparam logic [11:0] OFS_OUTPUT   = 12'h018;
	localparam logic [11:0] OFS_ISC      = 12'h01C;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h020;
	localparam logic [11:0] OFS_IRQ_EN   = 12'h024;
	localparam logic [11:0] OFS_IRQ_CLR  = 12'h028;
	localparam logic [11:0] OFS_OVF_CLR  = 12'h02C;

	// Field positions.
	localparam int CFG_DAP   = 0;
	localparam int CFG_CKP   = 1;
	localparam int CFG_LEN8  = 2;
	localparam int CFG_LSB   = 3;
	localparam int CFG_CONT  = 4;
	localparam int ST_SE     = 0;
	localparam int ST_TSF    = 1;
	localparam int ST_BFF    = 2;
	localparam int ST_OVF    = 3;
	localparam int OUT_OE    = 0;
	localparam int OUT_LVL   = 1;
	localparam int ISC_SSIE  = 7;
	localparam int IRQ_XFER  = 0;
	localparam int IRQ_OVR   = 1;

	// Word lengths in bits.
	localparam logic [3:0] LEN_SHORT = 4'h7;
	localparam logic [3:0] LEN_LONG  = 4'h8;

	// APB request and response.
	typedef struct packed {
		logic [11:0] paddr;
		logic        pwrite;
		logic        psel;
		logic        penable;
		logic [31:0] pwdata;
	} ssst_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ssst_apb_rsp_t;

	// Complete state of the channel.
	typedef struct packed {
		logic       sck_s1, sck_s2, sck_s3;
		logic       ssn_s1, ssn_s2;
		logic       sin_s1, sin_s2;
		logic [4:0] cfg;
		logic [1:0] isc_low;
		logic       ise;
		logic       op_en;
		logic       oe_bit;
		logic       lvl_bit;
		logic [7:0] txbuf;
		logic       bfull;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic       busy;
		logic       so;
		logic [7:0] rx;
		logic [7:0] rxbuf;
		logic       rx_full;
		logic       ovf;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic [31:0] prdata;
		logic       err;
	} ssst_state_t;

	// Value after reset: idle, output disabled, output level high.
	localparam ssst_state_t SSST_RST = '{sck_s1: 1'b1, sck_s2: 1'b1,
		sck_s3: 1'b1, ssn_s1: 1'b1, ssn_s2: 1'b1, lvl_bit: 1'b1,
		so: 1'b1, default: '0};

endpackage

// [hdl/ssst_slave_tx.sv]
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module ssst_slave_tx (
	// Clock, reset and clock enable.
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic                   ce,
	// APB slave.
	input  wire ssst_pkg::ssst_apb_req_t apb_req,
	output      ssst_pkg::ssst_apb_rsp_t apb_rsp,
	// Serial pins.
	input  wire logic                   serial_clock_pin,
	input  wire logic                   select_in_pin,
	input  wire logic                   serial_in_pin,
	output      logic                   serial_out_pin,
	output      logic                   serial_out_oe,
	// Interrupt.
	output      logic                   channel_interrupt
);
	import ssst_pkg::*;

	ssst_state_t st;
	ssst_state_t next_st;

	logic       select_in_n;
	logic       selected;
	logic       sck_now;
	logic       sck_old;
	logic       rise;
	logic       fall;
	logic       out_edge;
	logic       samp_edge;
	logic       run;
	logic       done;
	logic       load;
	logic [3:0] len;
	logic       setup;
	logic       acc;
	logic       wr;

	// Bit that leaves the shifter next, by direction and length.
	function automatic logic out_bit(input logic [7:0] v,
		input logic lsb, input logic len8);
		out_bit = lsb ? v[0] : (len8 ? v[7] : v[6]);
	endfunction

	// Shifter after one bit has left.
	function automatic logic [7:0] shifted(input logic [7:0] v,
		input logic lsb);
		shifted = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
	endfunction

	// Receive word after one more bit, aligned to the low bits.
	function automatic logic [7:0] rx_in(input logic [7:0] v,
		input logic b, input logic lsb, input logic len8);
		if (!lsb) begin
			rx_in = len8 ? {v[6:0], b} : {1'b0, v[5:0], b};
		end else begin
			rx_in = len8 ? {b, v[7:1]} : {1'b0, b, v[6:1]};
		end
	endfunction

	// Register read decode.
	function automatic logic [32:0] read_word(input ssst_state_t s,
		input logic [11:0] a);
		logic [31:0] d;
		logic        bad;
		d = '0;
		bad = 1'b0;
		unique case (a)
			OFS_CONFIG:   d[4:0] = s.cfg;
			OFS_STATUS:   d[3:0] = {s.ovf, s.bfull, s.busy | s.bfull, s.op_en};
			OFS_RXDATA:   d[7:0] = s.rxbuf;
			OFS_OUTPUT:   d[1:0] = {s.lvl_bit, s.oe_bit};
			OFS_ISC:      d[7:0] = {s.ise, 5'h00, s.isc_low};
			OFS_IRQ_STAT: d[1:0] = s.irq_stat;
			OFS_IRQ_EN:   d[1:0] = s.irq_en;
			OFS_START, OFS_STOP, OFS_TXDATA, OFS_IRQ_CLR,
			OFS_OVF_CLR:  d = '0;
			default:      bad = 1'b1;
		endcase
		read_word = {bad, d};
	endfunction

	// Next-state logic for the whole channel.
	always_comb begin
		next_st = st;
		// Two-flop synchronisers; the third clock flop finds edges.
		next_st.sck_s1 = serial_clock_pin;
		next_st.sck_s2 = st.sck_s1;
		next_st.sck_s3 = st.sck_s2;
		next_st.ssn_s1 = select_in_pin;
		next_st.ssn_s2 = st.ssn_s1;
		next_st.sin_s1 = serial_in_pin;
		next_st.sin_s2 = st.sin_s1;

		select_in_n = st.ise ? st.ssn_s2 : 1'b0;
		selected = !select_in_n;
		sck_now = st.sck_s2 ^ st.cfg[CFG_CKP];
		sck_old = st.sck_s3 ^ st.cfg[CFG_CKP];
		rise = sck_now && !sck_old;
		fall = !sck_now && sck_old;
		out_edge = st.cfg[CFG_DAP] ? rise : fall;
		samp_edge = st.cfg[CFG_DAP] ? fall : rise;
		len = st.cfg[CFG_LEN8] ? LEN_LONG : LEN_SHORT;
		run = st.busy && selected && st.op_en;

		setup = apb_req.psel && !apb_req.penable;
		acc = apb_req.psel && apb_req.penable;
		wr = acc && apb_req.pwrite;

		// Clears come first so that a same-cycle event still sets.
		if (wr && apb_req.paddr == OFS_IRQ_CLR) begin
			next_st.irq_stat = st.irq_stat & ~apb_req.pwdata[1:0];
		end
		if (wr && apb_req.paddr == OFS_OVF_CLR
			&& apb_req.pwdata[ST_OVF]) begin
			next_st.ovf = 1'b0;
		end
		if (acc && !apb_req.pwrite && apb_req.paddr == OFS_RXDATA) begin
			next_st.rx_full = 1'b0;
		end

		// Sample edge: take one bit and count it.
		done = 1'b0;
		if (run && samp_edge) begin
			next_st.rx = rx_in(st.rx, st.sin_s2, st.cfg[CFG_LSB],
				st.cfg[CFG_LEN8]);
			next_st.cnt = st.cnt - 4'h1;
			if (st.cnt == 4'h1) begin
				done = 1'b1;
				next_st.busy = 1'b0;
			end
		end

		// Output edge; in phase 1 the first bit is already out.
		if (run && out_edge && (!st.cfg[CFG_DAP] || st.cnt != len)) begin
			next_st.so = out_bit(st.sh, st.cfg[CFG_LSB],
				st.cfg[CFG_LEN8]);
			next_st.sh = shifted(st.sh, st.cfg[CFG_LSB]);
		end

		// End of a word: hand it over, flag overrun, signal the end in single mode.
		if (done) begin
			next_st.rxbuf = next_st.rx;
			next_st.rx_full = 1'b1;
			if (st.rx_full) begin
				next_st.ovf = 1'b1;
				next_st.irq_stat[IRQ_OVR] = 1'b1;
			end
			if (!st.cfg[CFG_CONT]) begin
				next_st.irq_stat[IRQ_XFER] = 1'b1;
			end
		end

		// Load the shifter from the buffer, selected or not.
		load = st.op_en && st.bfull && (!st.busy || done);
		if (load) begin
			next_st.sh = st.txbuf;
			next_st.cnt = len;
			next_st.busy = 1'b1;
			next_st.bfull = 1'b0;
			next_st.rx = '0;
			if (st.cfg[CFG_DAP]) begin
				next_st.so = out_bit(st.txbuf, st.cfg[CFG_LSB],
					st.cfg[CFG_LEN8]);
				next_st.sh = shifted(st.txbuf, st.cfg[CFG_LSB]);
			end
			if (st.cfg[CFG_CONT]) begin
				next_st.irq_stat[IRQ_XFER] = 1'b1;
			end
		end

		// Register writes.
		if (wr) begin
			unique case (apb_req.paddr)
				OFS_CONFIG: next_st.cfg = apb_req.pwdata[4:0];
				OFS_START: begin
					if (apb_req.pwdata[0]) begin
						next_st.op_en = 1'b1;
					end
				end
				OFS_STOP: begin
					if (apb_req.pwdata[0]) begin
						next_st.op_en = 1'b0;
						next_st.busy = 1'b0;
					end
				end
				OFS_TXDATA: begin
					next_st.txbuf = apb_req.pwdata[7:0];
					next_st.bfull = 1'b1;
				end
				OFS_OUTPUT: begin
					next_st.oe_bit = apb_req.pwdata[OUT_OE];
					next_st.lvl_bit = apb_req.pwdata[OUT_LVL];
				end
				OFS_ISC: begin
					next_st.ise = apb_req.pwdata[ISC_SSIE];
					next_st.isc_low = apb_req.pwdata[1:0];
				end
				OFS_IRQ_EN: next_st.irq_en = apb_req.pwdata[1:0];
				default: next_st.err = st.err;
			endcase
		end

		// Read data and error are captured in the setup cycle.
		if (setup) begin
			{next_st.err, next_st.prdata} = read_word(st, apb_req.paddr);
		end
	end

	// State register; reset wins, otherwise clock enable low freezes everything.
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= SSST_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Bus answer: one access cycle while the clock is enabled.
	assign apb_rsp.prdata = st.prdata;
	assign apb_rsp.pready = ce;
	assign apb_rsp.pslverr = st.err && apb_req.psel && apb_req.penable;

	// Data pin: shifter bit while the channel is started, idle level while stopped.
	assign serial_out_pin = st.op_en ? st.so : st.lvl_bit;
	assign serial_out_oe = st.oe_bit && selected;

	// Level interrupt from enabled sticky events.
	assign channel_interrupt = |(st.irq_stat & st.irq_en);

	// Checks on the channel behaviour.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst || !ce);

	sequence s_load_dap1;
		load && st.cfg[CFG_DAP] && !wr;
	endsequence

	sequence s_word_end;
		done && !wr;
	endsequence

	// The shared data line is released whenever the slave is unselected.
	a_out_hiz: assert property (
		!selected |-> !serial_out_oe)
		else $error("Data output driven while unselected.");

	// Unselected, the word in flight keeps its count.
	a_unsel_freeze: assert property (
		st.busy && !selected && !load && !wr
		|=> st.cnt == $past(st.cnt))
		else $error("Bit count moved while unselected.");

	// Unselected, neither the output bit nor the receive word moves.
	a_unsel_hold: assert property (
		st.busy && !selected && !load && !wr
		|=> $stable(st.so) && $stable(st.rx))
		else $error("Data moved while unselected.");

	// Phase 0 falling edge puts out the next bit.
	a_dap0_shift: assert property (
		run && fall && !st.cfg[CFG_DAP] && !wr && !load
		|=> st.so == $past(out_bit(st.sh, st.cfg[CFG_LSB],
		st.cfg[CFG_LEN8])))
		else $error("Phase 0 falling edge did not shift out.");

	// Phase 0 rising edge takes one bit.
	a_dap0_sample: assert property (
		run && rise && !st.cfg[CFG_DAP] && !wr && !load
		|=> st.cnt == $past(st.cnt) - 4'h1)
		else $error("Phase 0 rising edge did not sample.");

	// Phase 1 shows the first bit as soon as the word is loaded.
	a_dap1_first: assert property (
		s_load_dap1 |=> st.so ==
		$past(out_bit(st.txbuf, st.cfg[CFG_LSB], st.cfg[CFG_LEN8])))
		else $error("Phase 1 first bit not shown on load.");

	// Phase 1 falling edge takes one bit.
	a_dap1_sample: assert property (
		run && fall && st.cfg[CFG_DAP] && !wr && !load
		|=> st.cnt == $past(st.cnt) - 4'h1)
		else $error("Phase 1 falling edge did not sample.");

	// Phase 1 rising edge after a sample puts out the next bit.
	a_dap1_shift: assert property (
		run && rise && st.cfg[CFG_DAP] && st.cnt != len && !wr && !load
		|=> st.so == $past(out_bit(st.sh, st.cfg[CFG_LSB],
		st.cfg[CFG_LEN8])))
		else $error("Phase 1 rising edge did not shift out.");

	// A loaded word counts the configured number of bits.
	a_word_len: assert property (
		load && !wr |=> st.busy
		&& st.cnt == (st.cfg[CFG_LEN8] ? LEN_LONG : LEN_SHORT))
		else $error("Word length loaded wrongly.");

	// Single mode raises the event at the end of a word.
	a_single_end: assert property (
		s_word_end ##0 !st.cfg[CFG_CONT]
		|=> st.irq_stat[IRQ_XFER] && st.rx_full)
		else $error("Transfer end event missing.");

	// Continuous mode raises the event when the buffer empties.
	a_cont_empty: assert property (
		load && st.cfg[CFG_CONT] && !wr |=> st.irq_stat[IRQ_XFER])
		else $error("Buffer empty event missing.");

	// A word that ends over an unread one flags overrun.
	a_overrun: assert property (
		s_word_end ##0 st.rx_full
		|=> st.ovf && st.irq_stat[IRQ_OVR])
		else $error("Overrun not flagged.");

	// The overrun flag stays until software clears it.
	a_ovf_sticky: assert property (
		st.ovf && !wr |=> st.ovf)
		else $error("Overrun flag dropped by itself.");

	// A disabled select input means the channel is always selected.
	a_select_mask: assert property (
		!st.ise && st.op_en && st.oe_bit |-> serial_out_oe)
		else $error("Select pin not ignored when disabled.");

	// Writing the start bit enables the channel.
	a_start_en: assert property (
		wr && apb_req.paddr == OFS_START && apb_req.pwdata[0]
		|=> st.op_en)
		else $error("Start bit did not enable the channel.");

	// Writing the stop bit halts the channel and the word in flight.
	a_stop_halt: assert property (
		wr && apb_req.paddr == OFS_STOP && apb_req.pwdata[0]
		|=> !st.op_en && !st.busy)
		else $error("Stop bit did not halt the channel.");

	// A stopped channel shows the idle level on its data pin.
	a_idle_level: assert property (
		!st.op_en |-> serial_out_pin == st.lvl_bit)
		else $error("Idle level not shown while stopped.");

	// New transmit data replaces a pending word.
	a_tx_overwrite: assert property (
		wr && apb_req.paddr == OFS_TXDATA
		&& st.bfull && st.busy && !done |=> st.bfull
		&& st.txbuf == $past(apb_req.pwdata[7:0]))
		else $error("Pending transmit data not overwritten.");

	// Any transmit write leaves the buffer full.
	a_tx_full: assert property (
		wr && apb_req.paddr == OFS_TXDATA |=> st.bfull)
		else $error("Transmit write did not fill the buffer.");

endmodule

// [bench/ssst_master_model.sv]
`timescale 1ns/1ps
module ssst_master_model (
	// Lines driven toward the slave.
	output logic serial_clock_pin,
	output logic select_in_pin,
	output logic serial_in_pin,
	// Resolved data line from the slave.
	input  wire logic sdo
);
	initial begin
		serial_clock_pin = 1'b1;
		select_in_pin = 1'b1;
		serial_in_pin = 1'b0;
	end

	// One word of n bits; each half period is 16 ns, four clk cycles.
	task automatic xfer(input int n, input logic ckp, input logic dap,
		input logic sel, input logic [7:0] mo, output logic [7:0] mi);
		mi = 8'h00;
		#1;
		// Clock settles at its idle level before select falls.
		serial_clock_pin = ~ckp;
		#16;
		select_in_pin = ~sel;
		if (dap)
			serial_in_pin = mo[n - 1];
		#16;
		for (int i = n - 1; i >= 0; i--) begin
			serial_clock_pin = ckp;
			if (!dap)
				serial_in_pin = mo[i];
			#8;
			if (dap)
				mi[i] = sdo;
			#8;
			serial_clock_pin = ~ckp;
			if (dap && i > 0)
				serial_in_pin = mo[i - 1];
			#8;
			if (!dap)
				mi[i] = sdo;
			#8;
		end
		select_in_pin = 1'b1;
		// The serial input line then takes the inverse of its last value.
		serial_in_pin = ~serial_in_pin;
	endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import ssst_pkg::*;
	logic          clk = 1'b0;
	logic          srst = 1'b1;
	logic          ce = 1'b1;
	ssst_apb_req_t req = '0;
	ssst_apb_rsp_t rsp;
	logic          sck, ssn, si, so, oe, irq, err;
	int            miscompares = 0;
	int            num_checks = 0;
	int            cycles = 0;
	int            n;
	logic [7:0]    r, m, v;
	logic [4:0]    cfg;
	logic [4:0]    cfgs [4] = '{5'h04, 5'h0B, 5'h02, 5'h0D};
	logic [7:0]    txv [4] = '{8'hA5, 8'h3C, 8'h96, 8'h5A};
	logic [7:0]    rxv [4] = '{8'hC3, 8'h5B, 8'h71, 8'h2E};
	// Tri-state data line with a pull-up.
	wire           sdo = oe ? so : 1'b1;

	always #2 clk = ~clk;

	ssst_slave_tx u_dut (.clk(clk), .srst(srst), .ce(ce), .apb_req(req),
		.apb_rsp(rsp), .serial_clock_pin(sck), .select_in_pin(ssn),
		.serial_in_pin(si), .serial_out_pin(so), .serial_out_oe(oe),
		.channel_interrupt(irq));
	ssst_master_model u_mst (.serial_clock_pin(sck), .select_in_pin(ssn),
		.serial_in_pin(si), .sdo(sdo));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask

	// One APB transfer: setup cycle, then access until pready is high.
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		req <= '{paddr: a, pwrite: w, psel: 1'b1, penable: 1'b0, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(a, 1'b0, 32'h0, q);
		chk($sformatf("register %h", a), e, q);
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Bit order on the wire: first bit at position n-1.
	function automatic logic [7:0] conv(input logic [7:0] x, input int n,
		input logic lsb);
		conv = 8'h00;
		for (int i = 0; i < n; i++)
			conv[n - 1 - i] = lsb ? x[i] : x[n - 1 - i];
	endfunction

	// Cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(OFS_OUTPUT, 32'h2);
		rd(OFS_STATUS, 32'h0);
		chk("oe", 32'h0, oe);
		rd(12'h3FC, 32'h0);
		chk("pslverr", 32'h1, err);
		wr(OFS_IRQ_EN, 32'h1);
		wr(OFS_OUTPUT, 32'h3);
		wr(OFS_ISC, 32'h80);
		wr(OFS_START, 32'h1);
		rd(OFS_STATUS, 32'h1);
		tick(3);
		chk("oe unselected", 32'h0, oe);
		wr(OFS_ISC, 32'h0);
		tick(3);
		chk("oe pin ignored", 32'h1, oe);
		wr(OFS_ISC, 32'h80);
		// Each data phase, clock phase, length and direction value, in four mixes.
		foreach (cfgs[k]) begin
			cfg = cfgs[k];
			n = cfg[CFG_LEN8] ? 8 : 7;
			m = cfg[CFG_LEN8] ? 8'hFF : 8'h7F;
			v = conv(txv[k], n, cfg[CFG_LSB]);
			wr(OFS_CONFIG, {27'h0, cfg});
			wr(OFS_TXDATA, {24'h0, txv[k]});
			tick(3);
			if (cfg[CFG_DAP])
				chk("first bit", {31'h0, v[n - 1]}, so);
			u_mst.xfer(n, cfg[CFG_CKP], cfg[CFG_DAP], 1'b0, 8'h00, r);
			chk("oe idle", 32'h0, oe);
			u_mst.xfer(n, cfg[CFG_CKP], cfg[CFG_DAP], 1'b1,
				conv(rxv[k], n, cfg[CFG_LSB]), r);
			chk("tx word", v, r);
			tick(4);
			chk("irq end", 32'h1, irq);
			rd(OFS_RXDATA, rxv[k] & m);
			wr(OFS_IRQ_CLR, 32'h1);
			tick(2);
			chk("irq cleared", 32'h0, irq);
		end
		// Continuous mode, overwrite of a full buffer, then overrun.
		wr(OFS_CONFIG, 32'h14);
		wr(OFS_TXDATA, 32'h11);
		wr(OFS_TXDATA, 32'h22);
		wr(OFS_TXDATA, 32'h33);
		rd(OFS_STATUS, 32'h7);
		u_mst.xfer(8, 1'b0, 1'b0, 1'b1, 8'h0F, r);
		chk("first word", 32'h11, r);
		u_mst.xfer(8, 1'b0, 1'b0, 1'b1, 8'hF0, r);
		chk("overwritten word", 32'h33, r);
		tick(4);
		rd(OFS_STATUS, 32'h9);
		rd(OFS_IRQ_STAT, 32'h3);
		wr(OFS_IRQ_EN, 32'h0);
		tick(2);
		chk("irq masked", 32'h0, irq);
		wr(OFS_IRQ_EN, 32'h3);
		tick(2);
		chk("irq enabled", 32'h1, irq);
		wr(OFS_OVF_CLR, 32'h8);
		wr(OFS_IRQ_CLR, 32'h3);
		tick(2);
		chk("irq clear", 32'h0, irq);
		rd(OFS_STATUS, 32'h1);
		wr(OFS_STOP, 32'h1);
		rd(OFS_STATUS, 32'h0);
		wr(OFS_OUTPUT, 32'h0);
		tick(2);
		chk("oe off", 32'h0, oe);
		chk("level", 32'h0, so);
		// Clock enable low stalls the bus.
		@(posedge clk);
		ce <= 1'b0;
		tick(2);
		chk("pready stalled", 32'h0, rsp.pready);
		@(posedge clk);
		ce <= 1'b1;
		// Whole-unit reset after the stop.
		@(posedge clk);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(OFS_CONFIG, 32'h0);
		rd(OFS_OUTPUT, 32'h2);
		chk("irq after reset", 32'h0, irq);
		end_of_test();
	end
endmodule
